// file: hdl/fbs_pkg.sv
/*
 * fbs_pkg: shared constants and types for the fieldbus state and status block.
 * assumes: one clock domain, register reads by plain address port.
 */
package fbs_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] OFS_STATUS_WORD = 16'h1B04; // drive status word
  localparam logic [15:0] OFS_WARN_LATCH = 16'h1C18; // latched warning bits

  // ----------------------------------------------------------------
  // status word bit positions
  // ----------------------------------------------------------------
  localparam int SW_VOLT_EN = 4; // voltage enabled
  localparam int SW_ERR_CL0 = 7; // class 0 present
  localparam int SW_HALT = 8; // halt request pending
  localparam int SW_REMOTE = 9; // remote control
  localparam int SW_ERR_CL14 = 13; // class 1..4 present
  localparam int SW_MOT_END = 14; // motion end
  localparam int SW_REF_OK = 15; // reference valid

  // ----------------------------------------------------------------
  // warning word bit positions
  // ----------------------------------------------------------------
  localparam int WB_GENERAL = 0;
  localparam int WB_PS_TEMP = 1;
  localparam int WB_MOT_TEMP = 2;
  localparam int WB_RSVD3 = 3;
  localparam int WB_PS_OVL = 4;
  localparam int WB_MOT_OVL = 5;
  localparam int WB_BR_OVL = 6;
  localparam int WB_CAN = 7;
  localparam int WB_ENCODER = 8;
  localparam int WB_SERIAL = 9;
  localparam int WB_STO = 10;
  localparam int WB_UNDERVOLT = 11;
  localparam int WB_PROFIBUS = 12;
  localparam int WB_CAPTURE = 13;
  localparam int WB_ETHERNET = 14;
  localparam int WB_RSVD15 = 15;

  // auto-clearing warning bits (10, 11, 13)
  localparam logic [15:0] WARN_AUTO_MASK = 16'h2C00;
  // reserved warning bits (3, 15) always read zero
  localparam logic [15:0] WARN_RSVD_MASK = 16'h8008;
  localparam logic [15:0] WARN_RESET = 16'h0000;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // communication states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_INIT, ST_PREOP, ST_SAFEOP, ST_OP, ST_BOOT
  } fbs_state_e;

  // raw drive status inputs
  typedef struct packed {
    logic [5:0] stateBits; // bits 0..3,5,6
    logic voltEnabled;
    logic haltReq;
    logic remote;
    logic opMode10;
    logic opMode12;
    logic motionEnd;
    logic refValid;
    logic errClass0;
    logic errClass14;
  } fbs_drive_s;

  // data gates derived from state
  typedef struct packed {
    logic mailboxOn;
    logic inputsOn;
    logic outputsOn;
  } fbs_gate_s;
endpackage : fbs_pkg

// file: hdl/fbs_sync3.sv
/*
 * fbs_sync3: three-flop synchroniser; output changes once stages two and three agree.
 * assumes: input from outside the ref_clk domain.
 */
`timescale 1ns/1ps
module fbs_sync3 #(
  parameter int W = 16
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_q; // first stage, read only by s2
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] agree;

  // ----------------------------------------------------------------
  // shift stages
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      dout <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      dout <= agree;
    end
  end

  // per bit: take new value only when two and three agree
  assign agree = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & dout);
endmodule : fbs_sync3

// file: hdl/fbs_state_status.sv
/*
 * fbs_state_status: fieldbus communication state machine with data gating,
 * event-driven drive status word and latched warning word.
 * assumes: master state requests and strobes come from ref_clk logic;
 * drive conditions come from pins and are synchronised here.
 */
`timescale 1ns/1ps
module fbs_state_status (
  input wire logic ref_clk,
  input wire logic resetn,
  // master state request (same clock)
  input wire logic reqValid,
  input wire fbs_pkg::fbs_state_e reqState,
  input wire logic mappingValid,
  // process data from master (same clock)
  input wire logic outDataValid,
  input wire logic [31:0] outData,
  // input data from drive (same clock)
  input wire logic [31:0] inData,
  // mailbox from master (same clock)
  input wire logic mbxValid,
  input wire logic [15:0] mbxData,
  // drive conditions from pins
  input wire fbs_pkg::fbs_drive_s driveStat,
  input wire logic [15:0] warnCond,
  input wire logic faultReset,
  // register read port
  input wire logic [15:0] regAddr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  output logic regAck,
  // state and gated data out
  output fbs_pkg::fbs_state_e curState,
  output fbs_pkg::fbs_gate_s gates,
  output logic [31:0] txInData,
  output logic txInValid,
  output logic [31:0] cmdOutData,
  output logic cmdOutValid,
  output logic [15:0] mbxRxData,
  output logic mbxRxValid,
  output logic [15:0] txStatus,
  output logic txStatusValid,
  output logic restartReq
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  fbs_pkg::fbs_state_e state_q; // current state
  fbs_pkg::fbs_state_e state_d;
  logic [15:0] drvSync; // synchronised drive bits
  logic [15:0] drvRaw; // packed drive bits before sync
  logic [15:0] warnSync; // synchronised warning conditions
  logic faultSync; // synchronised fault reset level
  logic faultPrev_q; // for rising edge of fault reset
  logic faultEdge;
  logic [15:0] status_q; // drive status word
  logic [15:0] status_d;
  logic [15:0] warn_q; // latched warning word
  logic [15:0] warn_d;
  logic legal; // requested transition is listed
  logic mbxOn;
  logic inOn;
  logic outOn;
  logic [15:0] rdMux;
  logic rdHit;

  // ----------------------------------------------------------------
  // transition table
  // ----------------------------------------------------------------
  function automatic logic isLegal(input fbs_pkg::fbs_state_e from,
                                   input fbs_pkg::fbs_state_e to, input logic mapOk);
    logic ok;
    ok = 1'b0;
    case (from)
      fbs_pkg::ST_INIT: ok = (to == fbs_pkg::ST_PREOP) || (to == fbs_pkg::ST_BOOT);
      fbs_pkg::ST_PREOP: ok = (to == fbs_pkg::ST_INIT) ||
                              ((to == fbs_pkg::ST_SAFEOP) && mapOk);
      fbs_pkg::ST_SAFEOP: ok = (to == fbs_pkg::ST_PREOP) || (to == fbs_pkg::ST_OP) ||
                               (to == fbs_pkg::ST_INIT);
      fbs_pkg::ST_OP: ok = (to == fbs_pkg::ST_SAFEOP) || (to == fbs_pkg::ST_PREOP) ||
                           (to == fbs_pkg::ST_INIT);
      fbs_pkg::ST_BOOT: ok = (to == fbs_pkg::ST_INIT);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : isLegal

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  assign drvRaw = {driveStat.refValid, driveStat.motionEnd, driveStat.errClass14,
                   driveStat.opMode12, 1'b0, driveStat.opMode10, driveStat.remote,
                   driveStat.haltReq, driveStat.errClass0, driveStat.stateBits[5:4],
                   driveStat.voltEnabled, driveStat.stateBits[3:0]};

  // drive status bits
  fbs_sync3 #(.W(16)) uSyncDrv (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .din(drvRaw),
    .dout(drvSync)
  );

  // warning conditions plus fault reset
  fbs_sync3 #(.W(16)) uSyncWarn (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .din(warnCond),
    .dout(warnSync)
  );

  fbs_sync3 #(.W(1)) uSyncFault (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .din(faultReset),
    .dout(faultSync)
  );

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  assign legal = reqValid && isLegal(state_q, reqState, mappingValid);
  assign state_d = legal ? reqState : state_q;

  // state register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= fbs_pkg::ST_INIT;
    end else begin
      state_q <= state_d;
    end
  end

  // gates follow the next state, so each transition starts/stops services at once
  assign mbxOn = (state_d == fbs_pkg::ST_PREOP) || (state_d == fbs_pkg::ST_SAFEOP) ||
                 (state_d == fbs_pkg::ST_OP);
  assign inOn = (state_d == fbs_pkg::ST_SAFEOP) || (state_d == fbs_pkg::ST_OP);
  assign outOn = (state_d == fbs_pkg::ST_OP);

  // ----------------------------------------------------------------
  // status word and warning word
  // ----------------------------------------------------------------
  // class summaries sit at positions 7 and 13 of the packed word
  always_comb begin
    status_d = drvSync;
    status_d[fbs_pkg::SW_ERR_CL0] = drvSync[fbs_pkg::SW_ERR_CL0];
    status_d[fbs_pkg::SW_ERR_CL14] = drvSync[fbs_pkg::SW_ERR_CL14];
  end

  assign faultEdge = faultSync && !faultPrev_q;

  // latched bits set wins over fault reset; auto bits follow condition
  always_comb begin
    warn_d = faultEdge ? fbs_pkg::WARN_RESET : warn_q;
    warn_d = warn_d | warnSync;
    warn_d = (warn_d & ~fbs_pkg::WARN_AUTO_MASK) |
             (warnSync & fbs_pkg::WARN_AUTO_MASK);
    warn_d = warn_d & ~fbs_pkg::WARN_RSVD_MASK;
  end

  // status, warning and fault edge registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      status_q <= fbs_pkg::STATUS_RESET;
      warn_q <= fbs_pkg::WARN_RESET;
      faultPrev_q <= 1'b0;
    end else begin
      status_q <= status_d;
      warn_q <= warn_d;
      faultPrev_q <= faultSync;
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  assign rdHit = (regAddr == fbs_pkg::OFS_STATUS_WORD) ||
                 (regAddr == fbs_pkg::OFS_WARN_LATCH);
  assign rdMux = (regAddr == fbs_pkg::OFS_STATUS_WORD) ? status_q :
                 (regAddr == fbs_pkg::OFS_WARN_LATCH) ? warn_q : 16'h0000;

  // read answer one cycle after strobe; unmapped reads zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= 16'h0000;
      regAck <= 1'b0;
    end else begin
      regAck <= regRd;
      regRdata <= (regRd && rdHit) ? rdMux : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // gated data paths and event-driven status
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      curState <= fbs_pkg::ST_INIT;
      gates <= '0;
      txInData <= 32'h0000_0000;
      txInValid <= 1'b0;
      cmdOutData <= 32'h0000_0000;
      cmdOutValid <= 1'b0;
      mbxRxData <= 16'h0000;
      mbxRxValid <= 1'b0;
      txStatus <= fbs_pkg::STATUS_RESET;
      txStatusValid <= 1'b0;
      restartReq <= 1'b0;
    end else begin
      curState <= state_d;
      gates <= '{mailboxOn: mbxOn, inputsOn: inOn, outputsOn: outOn};
      // inputs sampled every cycle while input update runs
      txInValid <= inOn;
      if (inOn) begin
        txInData <= inData;
      end
      // outputs only acted on in operational
      cmdOutValid <= outDataValid && outOn;
      if (outDataValid && outOn) begin
        cmdOutData <= outData;
      end
      // mailbox passes only while mailbox runs
      mbxRxValid <= mbxValid && mbxOn;
      if (mbxValid && mbxOn) begin
        mbxRxData <= mbxData;
      end
      // status sent on change while inputs run
      txStatusValid <= inOn && (status_d != status_q);
      if (status_d != status_q) begin
        txStatus <= status_d;
      end
      // one-cycle restart pulse when bootstrap returns to init
      restartReq <= legal && (state_q == fbs_pkg::ST_BOOT);
    end
  end
endmodule : fbs_state_status

// file: verif/fbs_state_status_assertions.sv
/* checker for fbs_state_status: state gating, data gating, boot exit.
   assumes: bound to the block, sees its ports only. */
`timescale 1ns/1ps
module fbs_state_status_checker (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic reqValid,
  input wire fbs_pkg::fbs_state_e reqState,
  input wire logic mappingValid,
  input wire logic outDataValid,
  input wire logic mbxValid,
  input wire fbs_pkg::fbs_state_e curState,
  input wire fbs_pkg::fbs_gate_s gates,
  input wire logic txInValid,
  input wire logic cmdOutValid,
  input wire logic mbxRxValid,
  input wire logic restartReq
);
  // ----
  // properties
  // ----
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // no request pending this cycle
  wire quiet = !reqValid;
  // master asks to leave bootstrap
  sequence s_bootExit;
    curState == fbs_pkg::ST_BOOT && reqValid && reqState == fbs_pkg::ST_INIT;
  endsequence
  // restart follows within a cycle
  sequence s_restart;
    ##[0:1] restartReq;
  endsequence
  a_init_no_mbx: assert property (curState == fbs_pkg::ST_INIT |-> !gates.mailboxOn)
    else $error("mailbox open in init");
  a_preop_no_pd: assert property (curState == fbs_pkg::ST_PREOP |-> gates == 3'h4)
    else $error("wrong gates in preop");
  a_map_needed: assert property (curState == fbs_pkg::ST_PREOP && reqValid &&
    reqState == fbs_pkg::ST_SAFEOP && !mappingValid |=> curState == fbs_pkg::ST_PREOP)
    else $error("left preop without mapping");
  a_safeop_drop: assert property (curState == fbs_pkg::ST_SAFEOP && quiet &&
    outDataValid |=> !cmdOutValid) else $error("output taken in safeop");
  a_op_accept: assert property (curState == fbs_pkg::ST_OP && quiet &&
    outDataValid |=> cmdOutValid) else $error("output lost in op");
  a_mbx_accept: assert property (curState == fbs_pkg::ST_PREOP && quiet &&
    mbxValid |=> mbxRxValid) else $error("mailbox lost in preop");
  a_inputs_run: assert property (txInValid ==
    (curState inside {fbs_pkg::ST_SAFEOP, fbs_pkg::ST_OP}))
    else $error("inputs not forwarded");
  a_op_to_preop: assert property (curState == fbs_pkg::ST_OP && reqValid &&
    reqState == fbs_pkg::ST_PREOP |=> gates == 3'h4) else $error("op to preop gates");
  a_bad_req: assert property (curState == fbs_pkg::ST_INIT && reqValid &&
    reqState inside {fbs_pkg::ST_SAFEOP, fbs_pkg::ST_OP} |=> curState == fbs_pkg::ST_INIT)
    else $error("unlisted transition taken");
  a_boot_restart: assert property (s_bootExit |=> s_restart)
    else $error("no restart on boot exit");
endmodule : fbs_state_status_checker
bind fbs_state_status fbs_state_status_checker u_chk (.ref_clk, .resetn, .reqValid,
  .reqState, .mappingValid, .outDataValid, .mbxValid, .curState, .gates, .txInValid,
  .cmdOutValid, .mbxRxValid, .restartReq);

// file: verif/fbs_master_model.sv
/* fieldbus master model: state requests, mapping, output data, mailbox.
   assumes: called by the bench; drives just after rising edges. */
`timescale 1ns/1ps
module fbs_master_model (
  input wire logic ref_clk,
  output fbs_pkg::fbs_state_e reqState,
  output logic reqValid,
  output logic mappingValid,
  output logic outDataValid,
  output logic [31:0] outData,
  output logic mbxValid,
  output logic [15:0] mbxData
);
  // idle master at time zero
  initial begin
    reqState = fbs_pkg::ST_INIT;
    reqValid = 1'h0;
    mappingValid = 1'h0;
    outDataValid = 1'h0;
    outData = 32'h0;
    mbxValid = 1'h0;
    mbxData = 16'h0;
  end
  // one-cycle state request, settled at the next falling edge
  task req(input fbs_pkg::fbs_state_e s);
    @(posedge ref_clk);
    reqValid <= 1'h1;
    reqState <= s;
    @(posedge ref_clk);
    reqValid <= 1'h0;
    @(negedge ref_clk);
  endtask : req
  // process-data mapping delivered or withdrawn
  task map(input logic v);
    @(posedge ref_clk);
    mappingValid <= v;
  endtask : map
  // one word, mailbox or output data; released lines invert
  task send(input logic mb, input logic [31:0] d);
    @(posedge ref_clk);
    mbxValid <= mb;
    outDataValid <= !mb;
    mbxData <= d[15:0];
    outData <= d;
    @(posedge ref_clk);
    mbxValid <= 1'h0;
    outDataValid <= 1'h0;
    mbxData <= ~d[15:0];
    outData <= ~d;
    @(negedge ref_clk);
  endtask : send
endmodule : fbs_master_model

// file: verif/fbs_state_status_tb_top.sv
/* bench for fbs_state_status: states, gating, status event, warnings.
   assumes: master model beside the block, 25 MHz clock. */
`timescale 1ns/1ps
module fbs_state_status_tb_top;
  // ----
  // stimulus and wiring
  // ----
  logic ref_clk = 1'h0;
  logic resetn, reqValid, mappingValid, outDataValid, mbxValid, faultReset, regRd, regAck;
  logic txInValid, cmdOutValid, mbxRxValid, txStatusValid, restartReq, restartSeen;
  logic [31:0] outData, inData, txInData, cmdOutData;
  logic [15:0] mbxData, warnCond, regAddr, regRdata, mbxRxData, txStatus, v;
  fbs_pkg::fbs_state_e reqState, curState;
  fbs_pkg::fbs_drive_s driveStat;
  fbs_pkg::fbs_gate_s gates;
  int error_cnt, num_checks;
  always #20 ref_clk = ~ref_clk;
  fbs_master_model m (.ref_clk, .reqState, .reqValid, .mappingValid, .outDataValid,
    .outData, .mbxValid, .mbxData);
  fbs_state_status DUT (.ref_clk, .resetn, .reqValid, .reqState, .mappingValid,
    .outDataValid, .outData, .inData, .mbxValid, .mbxData, .driveStat, .warnCond,
    .faultReset, .regAddr, .regRd, .regRdata, .regAck, .curState, .gates, .txInData,
    .txInValid, .cmdOutData, .cmdOutValid, .mbxRxData, .mbxRxValid, .txStatus,
    .txStatusValid, .restartReq);
  // remember a restart pulse whenever it comes
  // single driver; an unknown start value reads as not seen
  always @(posedge ref_clk) restartSeen <= (restartReq === 1'h1) || (restartSeen === 1'h1);
  // wide enough for a valid bit on top of a 32-bit word
  task chk(input logic [32:0] seen, input logic [32:0] exp, input string nm);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk
  task summarize;
    $display("checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  // request state s (0 init,1 preop,2 safeop,3 op,4 boot), expect state e, gates g
  task go(input logic [2:0] s, input logic [2:0] e, input logic [2:0] g);
    m.req(fbs_pkg::fbs_state_e'(s));
    chk(curState, e, "state");
    chk(gates, g, "gates");
  endtask : go
  task rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge ref_clk);
    regRd <= 1'h0;
    @(negedge ref_clk);
    chk(regAck, 1'h1, "ack");
    d = regRdata;
  endtask : rd
  // ----
  // scenarios
  // ----
  task t_states;
    go(3'h2, 3'h0, 3'h0);
    go(3'h1, 3'h1, 3'h4);
    go(3'h2, 3'h1, 3'h4);
    m.map(1'h1);
    go(3'h2, 3'h2, 3'h6);
    go(3'h3, 3'h3, 3'h7);
    go(3'h2, 3'h2, 3'h6);
    go(3'h3, 3'h3, 3'h7);
    go(3'h1, 3'h1, 3'h4);
    go(3'h0, 3'h0, 3'h0);
    go(3'h1, 3'h1, 3'h4);
    go(3'h2, 3'h2, 3'h6);
    go(3'h0, 3'h0, 3'h0);
    go(3'h4, 3'h4, 3'h0);
    chk(restartSeen, 1'h0, "early restart");
    go(3'h0, 3'h0, 3'h0);
    repeat (2) @(negedge ref_clk);
    chk(restartSeen, 1'h1, "restart");
    $display("state walk done");
  endtask : t_states
  task t_data;
    m.send(1'h1, 32'h1234);
    chk(mbxRxValid, 1'h0, "init mbx");
    go(3'h1, 3'h1, 3'h4);
    m.send(1'h1, 32'hA5A5);
    chk({mbxRxValid, mbxRxData}, 17'h1A5A5, "preop mbx");
    m.send(1'h0, 32'h11);
    chk(cmdOutValid, 1'h0, "preop out");
    go(3'h2, 3'h2, 3'h6);
    m.send(1'h0, 32'h22);
    chk(cmdOutValid, 1'h0, "safeop out");
    chk({txInValid, txInData}, 33'h1C0DE0001, "inputs");
    go(3'h3, 3'h3, 3'h7);
    m.send(1'h0, 32'h87654321);
    chk({cmdOutValid, cmdOutData}, 33'h187654321, "op out");
    $display("data gating done");
  endtask : t_data
  task t_status;
    int n;
    // volt, halt, remote, motion end, ref ok, class 0 and class 1..4
    @(posedge ref_clk) driveStat <= 15'h1CF;
    n = 0;
    while (txStatusValid !== 1'h1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    chk(n < 20, 1'h1, "event");
    chk(txStatus, 16'hE390, "status tx");
    rd(fbs_pkg::OFS_STATUS_WORD, v);
    chk(v, 16'hE390, "status reg");
    $display("status word done");
  endtask : t_status
  task t_warn;
    @(posedge ref_clk) warnCond <= 16'hFFFF;
    repeat (8) @(posedge ref_clk);
    rd(fbs_pkg::OFS_WARN_LATCH, v);
    chk(v, 16'h7FF7, "warn set");
    @(posedge ref_clk) warnCond <= 16'h0;
    repeat (8) @(posedge ref_clk);
    rd(fbs_pkg::OFS_WARN_LATCH, v);
    chk(v, 16'h53F7, "warn held");
    @(posedge ref_clk) faultReset <= 1'h1;
    repeat (8) @(posedge ref_clk);
    faultReset <= 1'h0;
    rd(fbs_pkg::OFS_WARN_LATCH, v);
    chk(v, 16'h0, "warn cleared");
    rd(16'h0000, v);
    chk(v, 16'h0, "unmapped");
    $display("warning word done");
  endtask : t_warn
  // main sequence
  initial begin
    resetn = 1'h0;
    regRd = 1'h0;
    regAddr = 16'h0;
    inData = 32'hC0DE0001;
    driveStat = 15'h0;
    warnCond = 16'h0;
    faultReset = 1'h0;
    repeat (16) @(posedge ref_clk);
    resetn <= 1'h1;
    t_states;
    t_data;
    t_status;
    t_warn;
    summarize;
  end
  // watchdog well beyond the hundred or so cycles of the run
  initial begin
    repeat (3000) @(posedge ref_clk);
    error_cnt++;
    summarize;
  end
endmodule : fbs_state_status_tb_top
